// File: dma_control_regs.svh
`ifndef DMA_CONTROL_REGS_SVH
`define DMA_CONTROL_REGS_SVH

// chip select window of the engine's own registers
`define DMA_CS_LO 8'hC0
`define DMA_CS_HI 8'hCE

// parallel status, control and auxiliary ports
`define STATUS_PORT 8'hD0
`define CONTROL_PORT 8'hD1
`define AUX_PORT 8'hD2

// i/o latch write ports
`define AVAIL1_PORT 8'h02
`define AVAIL2_PORT 8'h03
`define AVAIL3_PORT 8'h04
`define SEQ_CLEAR_PORT 8'h07

// engine register index that clears the byte pointer
`define IDX_BYTE_CLEAR 4'hC

// control port bit positions
`define CTL_CLEAR 0
`define CTL_READ_ADDR 1
`define CTL_FORCE_BAD 2
`define CTL_ACCEPT_ALL 3
`define CTL_NORMAL 4
`define CTL_LOOP 5
`define CTL_RX_EN 6
`define CTL_TX_EN 7

// auxiliary port bit positions
`define AUX_CABLE_LOOP 0
`define AUX_LED 1
`define AUX_LOCK 2

// reset values: all enables and loopbacks inactive
`define CONTROL_RESET 8'hFA
`define AUX_RESET 4'h5
`define SEQ_RESET 3'h1

// sram window as seen by the cpu; engine address 0 is its first byte
`define SRAM_CPU_BASE 20'hF0000
// receive base count that firmware loads (1521)
`define RX_FRAME_COUNT 16'h05F1

`endif

// File: dma_control_pkg.sv
`default_nettype none
package dma_control_pkg;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_WAIT = 6'h02,
      ST_ADDR = 6'h04,
      ST_STROBE = 6'h08,
      ST_READ = 6'h10,
      ST_WRITE = 6'h20
   } byte_latch_strobe_state_t;
   typedef logic [1:0] chan_idx_t;
   typedef logic [15:0] dma_word_t;
endpackage
`default_nettype wire

// File: dma_chan_if.sv
`default_nettype none
interface dma_chan_if;
   import dma_control_pkg::*;
   logic load;
   logic load_cnt;
   logic hi_byte;
   logic [7:0] wdata;
   logic step;
   logic reinit;
   dma_word_t cur_addr;
   dma_word_t cur_cnt;
   logic last;
   modport ctrl (output load, load_cnt, hi_byte, wdata, step, reinit,
                 input cur_addr, cur_cnt, last);
   modport chan (input load, load_cnt, hi_byte, wdata, step, reinit,
                 output cur_addr, cur_cnt, last);
endinterface
`default_nettype wire

// File: dma_channel.sv
`default_nettype none
module dma_channel
   import dma_control_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   dma_chan_if.chan bus
);
   dma_word_t base_addr_reg;
   dma_word_t base_cnt_reg;
   dma_word_t cur_addr_reg;
   dma_word_t cur_cnt_reg;

   // cpu load writes base and current together, one byte at a time
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         base_addr_reg <= 16'h0000;
         base_cnt_reg <= 16'h0000;
         cur_addr_reg <= 16'h0000;
         cur_cnt_reg <= 16'h0000;
      end else if (bus.load) begin
         if (bus.load_cnt && bus.hi_byte) begin
            base_cnt_reg[15:8] <= bus.wdata;
            cur_cnt_reg[15:8] <= bus.wdata;
         end else if (bus.load_cnt) begin
            base_cnt_reg[7:0] <= bus.wdata;
            cur_cnt_reg[7:0] <= bus.wdata;
         end else if (bus.hi_byte) begin
            base_addr_reg[15:8] <= bus.wdata;
            cur_addr_reg[15:8] <= bus.wdata;
         end else begin
            base_addr_reg[7:0] <= bus.wdata;
            cur_addr_reg[7:0] <= bus.wdata;
         end
      end else if (bus.reinit) begin
         cur_addr_reg <= base_addr_reg;
         cur_cnt_reg <= base_cnt_reg;
      end else if (bus.step) begin
         cur_addr_reg <= cur_addr_reg + 16'h0001;
         cur_cnt_reg <= cur_cnt_reg - 16'h0001;
      end
   end

   assign bus.cur_addr = cur_addr_reg;
   assign bus.cur_cnt = cur_cnt_reg;
   // this byte brings the count to zero
   assign bus.last = (cur_cnt_reg == 16'h0001);

   reinit_restores_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      bus.reinit && !bus.load |=> cur_addr_reg == $past(base_addr_reg)
         && cur_cnt_reg == $past(base_cnt_reg))
      else $error("autoinit did not restore base values");
   step_moves_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      bus.step && !bus.reinit && !bus.load |=> cur_addr_reg == $past(cur_addr_reg) + 16'h0001
         && cur_cnt_reg == $past(cur_cnt_reg) - 16'h0001)
      else $error("step did not advance address and count");
endmodule
`default_nettype wire

// File: dma_control.sv
`include "dma_control_regs.svh"
`default_nettype none
module dma_control
   import dma_control_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] cpu_io_addr_i,
   input wire logic cpu_io_rd_i,
   input wire logic cpu_io_wr_i,
   input wire logic [7:0] cpu_wdata_i,
   output logic [7:0] cpu_rdata_o,
   input wire logic transmit_request_i,
   input wire logic receive_request_synced_n_i,
   input wire logic receive_complete_pulse_i,
   input wire logic byte_ready_i,
   input wire logic end_of_process_n_i,
   output logic end_of_process_n_o,
   output logic end_of_process_oe_n_o,
   input wire logic host_interrupt_pending_i,
   input wire logic carrier_present_i,
   input wire logic transmit_in_progress_i,
   input wire logic length_error_i,
   input wire logic crc_error_i,
   input wire logic transmit_timeout_i,
   input wire logic transmit_collision_i,
   input wire logic [3:0] jumper_i,
   output logic hold_request_o,
   output logic cpu_lockout_o,
   output logic bus_grant_o,
   output logic onboard_ready_o,
   output logic address_enable_o,
   output logic address_strobe_o,
   output logic [7:0] dma_data_o,
   output logic [12:0] mem_addr_o,
   output logic dma_io_read_n_o,
   output logic dma_io_write_n_o,
   output logic dma_memory_read_n_o,
   output logic dma_memory_write_n_o,
   output logic receive_available_n_o,
   output logic [2:0] receive_done_o,
   output logic [7:0] serializer_control_o,
   output logic [3:0] aux_control_o
);
   byte_latch_strobe_state_t state_reg;
   chan_idx_t active_reg;
   logic hold_reg, lockout_reg, grant_reg, ready_reg;
   logic aen_reg, strobe_reg, ior_n_reg, iow_n_reg, memr_n_reg, dma_memory_write_n_n_reg;
   logic eop_n_reg, avail_n_reg, ptr_reg, rcp_d_reg;
   logic [7:0] data_reg, lo_reg, rdata_reg, ctl_reg;
   logic [4:0] hi_latch_reg;
   logic [3:0] aux_reg;
   logic [2:0] seq_reg, avail_reg, avail_next, done_reg;
   dma_word_t cur_addr_w [4];
   dma_word_t cur_cnt_w [4];
   logic [3:0] last_w, req_w, reinit_w;
   logic [2:0] rx_req_w, avail_set_w, rx_done_w;
   logic [3:0] idx_w;
   logic cs_w, prog_w, prog_wr_w, rx_w, last_now_w, stop_w, eop_evt_w, step_w;
   logic rcp_fall_w, crc_reinit_w, seq_clear_w;
   dma_word_t sel_word_w;
   logic [7:0] status_w, rd_mux_w;

   // engine select decode and program condition
   assign cs_w = (cpu_io_rd_i || cpu_io_wr_i) && cpu_io_addr_i >= `DMA_CS_LO
      && cpu_io_addr_i <= `DMA_CS_HI;
   assign prog_w = cs_w && !hold_reg && state_reg == ST_IDLE;
   assign prog_wr_w = prog_w && cpu_io_wr_i;
   assign idx_w = cpu_io_addr_i[3:0];

   // receive requests gated by the sequencer
   assign rx_req_w = receive_request_synced_n_i ? 3'h0 : seq_reg;
   assign req_w = {rx_req_w, transmit_request_i};
   assign rx_w = (active_reg != 2'h0);
   assign last_now_w = last_w[active_reg];
   assign step_w = (state_reg == ST_WRITE);
   assign eop_evt_w = step_w && (last_now_w || !end_of_process_n_i);
   // transmit ignores request loss; receive stops on any of three
   assign stop_w = rx_w ? (eop_evt_w || !req_w[active_reg]) : last_now_w;
   assign rcp_fall_w = rcp_d_reg && !receive_complete_pulse_i;
   assign crc_reinit_w = rcp_fall_w && ctl_reg[`CTL_NORMAL] && crc_error_i;
   assign rx_done_w = (rcp_fall_w && !crc_reinit_w) ? seq_reg : 3'h0;
   assign seq_clear_w = cpu_io_wr_i && cpu_io_addr_i == `SEQ_CLEAR_PORT;
   assign avail_set_w = {3{cpu_io_wr_i}} & {cpu_io_addr_i == `AVAIL3_PORT,
      cpu_io_addr_i == `AVAIL2_PORT, cpu_io_addr_i == `AVAIL1_PORT};

   // autoinit of the served channel, or of the receive channel on crc error in normal mode
   always_comb begin
      reinit_w = 4'h0;
      if (eop_evt_w) begin
         reinit_w[active_reg] = 1'b1;
      end
      if (crc_reinit_w) begin
         reinit_w[3:1] = reinit_w[3:1] | seq_reg;
      end
   end

   // four channel register sets
   for (genvar g = 0; g < 4; g++) begin : g_ch
      dma_chan_if cif ();
      assign cif.load = prog_wr_w && !idx_w[3] && idx_w[2:1] == 2'(g);
      assign cif.load_cnt = idx_w[0];
      assign cif.hi_byte = ptr_reg;
      assign cif.wdata = cpu_wdata_i;
      assign cif.step = step_w && active_reg == 2'(g);
      assign cif.reinit = reinit_w[g];
      assign cur_addr_w[g] = cif.cur_addr;
      assign cur_cnt_w[g] = cif.cur_cnt;
      assign last_w[g] = cif.last;
      dma_channel u_ch (
         .clk_i(clk_i),
         .sys_rst_i(sys_rst_i),
         .bus(cif.chan)
      );
   end

   // status port and cpu read mux
   assign status_w = {transmit_collision_i, transmit_timeout_i, crc_error_i, length_error_i,
      transmit_in_progress_i, carrier_present_i, grant_reg, host_interrupt_pending_i};
   assign sel_word_w = idx_w[0] ? cur_cnt_w[idx_w[2:1]] : cur_addr_w[idx_w[2:1]];
   always_comb begin
      rd_mux_w = 8'h00;
      if (prog_w && !idx_w[3]) begin
         rd_mux_w = ptr_reg ? sel_word_w[15:8] : sel_word_w[7:0];
      end else if (cpu_io_addr_i == `STATUS_PORT) begin
         rd_mux_w = status_w;
      end else if (cpu_io_addr_i == `CONTROL_PORT) begin
         rd_mux_w = ctl_reg;
      end else if (cpu_io_addr_i == `AUX_PORT) begin
         rd_mux_w = {jumper_i, aux_reg};
      end
   end

   // cpu read data and byte pointer
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rdata_reg <= 8'h00;
         ptr_reg <= 1'b0;
      end else begin
         if (cpu_io_rd_i) begin
            rdata_reg <= rd_mux_w;
         end
         if (prog_w && idx_w == `IDX_BYTE_CLEAR && cpu_io_wr_i) begin
            ptr_reg <= 1'b0;
         end else if (prog_w && !idx_w[3]) begin
            ptr_reg <= !ptr_reg;
         end
      end
   end

   // control and auxiliary output ports
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ctl_reg <= `CONTROL_RESET;
         aux_reg <= `AUX_RESET;
      end else if (cpu_io_wr_i && cpu_io_addr_i == `CONTROL_PORT) begin
         ctl_reg <= cpu_wdata_i;
      end else if (cpu_io_wr_i && cpu_io_addr_i == `AUX_PORT) begin
         aux_reg <= cpu_wdata_i[3:0];
      end
   end
   assign serializer_control_o = ctl_reg;
   assign aux_control_o = aux_reg;

   // receive sequencer: clear by port write, rotate on trailing edge
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         seq_reg <= `SEQ_RESET;
         rcp_d_reg <= 1'b0;
      end else begin
         rcp_d_reg <= receive_complete_pulse_i;
         if (seq_clear_w) begin
            seq_reg <= `SEQ_RESET;
         end else if (rcp_fall_w) begin
            seq_reg <= {seq_reg[1:0], seq_reg[2]};
         end
      end
   end

   // receive available latches; a set beats a same-cycle clear
   always_comb begin
      avail_next = avail_reg & ~rx_done_w;
      avail_next = avail_next | avail_set_w;
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         avail_reg <= 3'h0;
         avail_n_reg <= 1'b1;
         done_reg <= 3'h0;
      end else begin
         avail_reg <= avail_next;
         avail_n_reg <= ~|avail_next;
         done_reg <= rx_done_w;
      end
   end

   // bus arbiter: lockout then grant, ready is inverted grant
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         lockout_reg <= 1'b0;
         grant_reg <= 1'b0;
         ready_reg <= 1'b1;
      end else begin
         lockout_reg <= hold_reg;
         grant_reg <= hold_reg && lockout_reg;
         ready_reg <= !(hold_reg && lockout_reg);
      end
   end

   // transfer sequencer
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_reg <= ST_IDLE;
         active_reg <= 2'h0;
         hold_reg <= 1'b0;
         aen_reg <= 1'b0;
         strobe_reg <= 1'b0;
         data_reg <= 8'h00;
         lo_reg <= 8'h00;
         hi_latch_reg <= 5'h00;
         ior_n_reg <= 1'b1;
         iow_n_reg <= 1'b1;
         memr_n_reg <= 1'b1;
         dma_memory_write_n_n_reg <= 1'b1;
         eop_n_reg <= 1'b1;
      end else begin
         eop_n_reg <= !(step_w && last_now_w);
         case (state_reg)
            ST_IDLE: begin
               if (|req_w) begin
                  hold_reg <= 1'b1;
                  state_reg <= ST_WAIT;
                  if (req_w[0]) begin
                     active_reg <= 2'h0;
                  end else if (req_w[1]) begin
                     active_reg <= 2'h1;
                  end else if (req_w[2]) begin
                     active_reg <= 2'h2;
                  end else begin
                     active_reg <= 2'h3;
                  end
               end
            end
            ST_WAIT: begin
               if (grant_reg) begin
                  aen_reg <= 1'b1;
                  strobe_reg <= 1'b1;
                  data_reg <= cur_addr_w[active_reg][15:8];
                  lo_reg <= cur_addr_w[active_reg][7:0];
                  state_reg <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               strobe_reg <= 1'b0;
               hi_latch_reg <= data_reg[4:0];
               state_reg <= ST_STROBE;
            end
            ST_STROBE: begin
               // receive request gone before the next byte: give the bus back
               if (rx_w && !req_w[active_reg]) begin
                  hold_reg <= 1'b0;
                  aen_reg <= 1'b0;
                  state_reg <= ST_IDLE;
               end else if (byte_ready_i) begin
                  if (rx_w) begin
                     ior_n_reg <= 1'b0;
                  end else begin
                     memr_n_reg <= 1'b0;
                  end
                  state_reg <= ST_READ;
               end
            end
            ST_READ: begin
               if (rx_w) begin
                  dma_memory_write_n_n_reg <= !ctl_reg[`CTL_LOOP] || !aux_reg[`AUX_CABLE_LOOP];
               end else begin
                  iow_n_reg <= 1'b0;
               end
               state_reg <= ST_WRITE;
            end
            ST_WRITE: begin
               ior_n_reg <= 1'b1;
               iow_n_reg <= 1'b1;
               memr_n_reg <= 1'b1;
               dma_memory_write_n_n_reg <= 1'b1;
               if (stop_w) begin
                  hold_reg <= 1'b0;
                  aen_reg <= 1'b0;
                  state_reg <= ST_IDLE;
               end else begin
                  state_reg <= ST_WAIT;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   assign cpu_rdata_o = rdata_reg;
   assign end_of_process_n_o = eop_n_reg;
   assign end_of_process_oe_n_o = eop_n_reg;
   assign hold_request_o = hold_reg;
   assign cpu_lockout_o = lockout_reg;
   assign bus_grant_o = grant_reg;
   assign onboard_ready_o = ready_reg;
   assign address_enable_o = aen_reg;
   assign address_strobe_o = strobe_reg;
   assign dma_data_o = data_reg;
   assign mem_addr_o = {hi_latch_reg, lo_reg};
   assign dma_io_read_n_o = ior_n_reg;
   assign dma_io_write_n_o = iow_n_reg;
   assign dma_memory_read_n_o = memr_n_reg;
   assign dma_memory_write_n_o = dma_memory_write_n_n_reg;
   assign receive_available_n_o = avail_n_reg;
   assign receive_done_o = done_reg;

   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   idle_sample_a: assert property (
      state_reg == ST_IDLE && (|req_w) |=> state_reg == ST_WAIT && hold_request_o)
      else $error("idle engine missed a request");
   grant_order_a: assert property (
      $rose(hold_request_o) |=> cpu_lockout_o && !bus_grant_o ##1 bus_grant_o)
      else $error("lockout and grant out of order");
   ready_inverse_a: assert property (
      bus_grant_o |-> !onboard_ready_o && status_w[1])
      else $error("ready not inverse of grant");
   program_gate_a: assert property (
      cs_w && cpu_io_rd_i && hold_request_o |=> cpu_rdata_o == 8'h00)
      else $error("engine read served while holding");
   seq_clear_a: assert property (
      cpu_io_wr_i && cpu_io_addr_i == `SEQ_CLEAR_PORT |=> seq_reg == `SEQ_RESET)
      else $error("sequencer not cleared");
   avail_set_a: assert property (
      cpu_io_wr_i && cpu_io_addr_i == `AVAIL1_PORT |=> !receive_available_n_o && avail_reg[0])
      else $error("receive available not set");
   seq_rotate_a: assert property (
      rcp_fall_w && !seq_clear_w |=> seq_reg == {$past(seq_reg[1:0]), $past(seq_reg[2])})
      else $error("sequencer did not rotate");
   addr_latch_a: assert property (
      $fell(address_strobe_o) |-> address_enable_o && mem_addr_o[12:8] == $past(dma_data_o[4:0]))
      else $error("high address not latched on strobe fall");
   rx_order_a: assert property (
      $fell(dma_memory_write_n_o) |-> !$past(dma_io_read_n_o) && !dma_io_read_n_o)
      else $error("memory write without io read first");
   block_mode_a: assert property (
      state_reg == ST_WRITE && active_reg == 2'h0 && !last_now_w |=> state_reg == ST_WAIT)
      else $error("transmit block stopped early");
   demand_stop_a: assert property (
      (state_reg == ST_WRITE || state_reg == ST_STROBE) && rx_w && !req_w[active_reg]
         |=> state_reg == ST_IDLE ##2 !bus_grant_o)
      else $error("receive did not release bus");
endmodule
`default_nettype wire

// File: dummy_end_marker_not_used.sv
`default_nettype none
`default_nettype wire

// File: serdes_model.sv
`default_nettype none
module serdes_model (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic rx_go_i,
   input wire logic tx_go_i,
   input wire logic [3:0] gap_i,
   input wire logic [7:0] n_bytes_i,
   input wire logic strobe_n_i,
   input wire logic end_of_process_n_i,
   output logic byte_ready_o,
   output logic receive_request_synced_n_o,
   output logic transmit_request_o,
   output logic receive_complete_pulse_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rx_on, tx_on, strobe_q;
   logic [7:0] left;
   logic [3:0] wait_q;
   // far side byte handshake, one frame at a time, optional stall per byte
   always_ff @(posedge clk_i) begin
      strobe_q <= strobe_n_i;
      receive_complete_pulse_o <= 1'b0;
      transmit_request_o <= 1'b0;
      if (sys_rst_i) begin
         rx_on <= 1'b0;
         tx_on <= 1'b0;
         byte_ready_o <= 1'b0;
         receive_request_synced_n_o <= 1'b1;
         left <= 8'h00;
         wait_q <= 4'h0;
      end else if (rx_go_i || tx_go_i) begin
         rx_on <= rx_go_i;
         tx_on <= tx_go_i;
         transmit_request_o <= tx_go_i;
         left <= n_bytes_i;
         byte_ready_o <= 1'b1; // byte latched before the receive request; transmit request is raised in the same cycle
      end else begin
         if (rx_on && byte_ready_o)
            receive_request_synced_n_o <= 1'b0; // request only after byte ready
         // strobe release ends the byte; stall before offering the next
         if (!strobe_q && strobe_n_i) begin
            byte_ready_o <= 1'b0;
            wait_q <= gap_i;
            left <= left - 8'h01;
         end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
         end else if ((rx_on || tx_on) && left != 8'h00) begin
            byte_ready_o <= 1'b1;
         end
         // frame stored: drop request and pulse completion
         if (rx_on && left == 8'h00) begin
            rx_on <= 1'b0;
            receive_request_synced_n_o <= 1'b1;
            receive_complete_pulse_o <= 1'b1;
         end
         // end of process: release the bus
         if (!end_of_process_n_i) begin
            rx_on <= 1'b0;
            tx_on <= 1'b0;
            byte_ready_o <= 1'b0;
            receive_request_synced_n_o <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: test_packet_buffer_dma_control.sv
`include "dma_control_regs.svh"
`default_nettype none
module test_packet_buffer_dma_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, rd, wr, transmit_request, rqn, cmp, brdy, hold, lock, grant, rdy, address_enable, stb;
   logic eop_n, eop_oe_n, iord_n, iowr_n, memr_n, dma_memory_write_n_n, avail_n, rx_go, tx_go, first, memr_q;
   logic [7:0] addr, wdata, rdata, stat, dhi, sctl, nb;
   logic [3:0] gap, auxo;
   logic [2:0] done, seen;
   logic [12:0] maddr, waddr;
   int miscompares, n_tests, nrd, neop, niw;
   wire eop = eop_oe_n ? 1'b1 : eop_n; // pulled up when released
   wire [2:0] mon = {iord_n, stb, hold};
   dma_control dut_u (.clk_i(clk), .sys_rst_i(rst), .cpu_io_addr_i(addr), .cpu_io_rd_i(rd),
      .cpu_io_wr_i(wr), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata), .transmit_request_i(transmit_request),
      .receive_request_synced_n_i(rqn), .receive_complete_pulse_i(cmp), .byte_ready_i(brdy),
      .end_of_process_n_i(eop), .end_of_process_n_o(eop_n), .end_of_process_oe_n_o(eop_oe_n),
      .host_interrupt_pending_i(stat[0]), .carrier_present_i(stat[2]),
      .transmit_in_progress_i(stat[3]), .length_error_i(stat[4]), .crc_error_i(stat[5]),
      .transmit_timeout_i(stat[6]), .transmit_collision_i(stat[7]), .jumper_i(4'h9),
      .hold_request_o(hold), .cpu_lockout_o(lock), .bus_grant_o(grant), .onboard_ready_o(rdy),
      .address_enable_o(address_enable), .address_strobe_o(stb), .dma_data_o(dhi), .mem_addr_o(maddr),
      .dma_io_read_n_o(iord_n), .dma_io_write_n_o(iowr_n), .dma_memory_read_n_o(memr_n),
      .dma_memory_write_n_o(dma_memory_write_n_n), .receive_available_n_o(avail_n), .receive_done_o(done),
      .serializer_control_o(sctl), .aux_control_o(auxo));
   serdes_model far_u (.clk_i(clk), .sys_rst_i(rst), .rx_go_i(rx_go), .tx_go_i(tx_go),
      .gap_i(gap), .n_bytes_i(nb), .strobe_n_i(memr_n & dma_memory_write_n_n), .end_of_process_n_i(eop),
      .byte_ready_o(brdy), .receive_request_synced_n_o(rqn), .transmit_request_o(transmit_request),
      .receive_complete_pulse_o(cmp));
   always #20 clk = ~clk;
   // frame observations: done pulses, first write address, read strobes, end of process
   always @(posedge clk) begin
      seen = seen | done;
      if (!dma_memory_write_n_n && first) begin
         waddr = maddr;
         first = 1'b0;
      end
      if (!memr_n && memr_q)
         nrd++;
      if (!eop)
         neop++;
      if (!iowr_n)
         niw++;
      memr_q = memr_n;
   end
   task automatic conclude;
      $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // one cpu i/o access, then one edge for the answer to land
   task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #2;
      addr = a;
      wdata = d;
      wr = w;
      rd = !w;
      @(posedge clk);
      #2;
      wr = 1'b0;
      rd = 1'b0;
      @(posedge clk);
      #2;
   endtask
   task automatic peek(input logic [7:0] a, input logic [7:0] exp);
      io(1'b0, a, 8'h00);
      check(rdata, exp);
   endtask
   task automatic wait_on(input int i, input logic v);
      int k;
      k = 0;
      while (mon[i] !== v && k < 300) begin
         @(posedge clk);
         #2;
         k++;
      end
      if (k >= 300)
         check(16'h0000, 16'h0001);
   endtask
   task automatic prog(input logic [7:0] idx, input logic [15:0] base, input logic [15:0] cnt);
      io(1'b1, 8'hC0 + idx, base[7:0]);
      io(1'b1, 8'hC0 + idx, base[15:8]);
      io(1'b1, 8'hC1 + idx, cnt[7:0]);
      io(1'b1, 8'hC1 + idx, cnt[15:8]);
   endtask
   // start one frame at the far side; finish_frame waits until the bus is given back
   task automatic frame(input logic tx, input logic [7:0] n, input logic [3:0] g);
      seen = 3'h0;
      first = 1'b1;
      nrd = 0;
      neop = 0;
      niw = 0;
      nb = n;
      gap = g;
      rx_go = !tx;
      tx_go = tx;
      @(posedge clk);
      #2;
      rx_go = 1'b0;
      tx_go = 1'b0;
   endtask
   task automatic finish_frame;
      wait_on(0, 1'b1);
      wait_on(0, 1'b0);
      repeat (8) @(posedge clk);
      #2;
   endtask
   // cut a hang short; the tests need well under 2000 cycles
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      conclude();
   end
   initial begin
      {clk, rd, wr, rx_go, tx_go, first, nb, gap, seen} = '0;
      {addr, wdata, memr_q, nrd, neop, niw} = '0;
      stat = 8'hD5;
      rst = 1'b1;
      repeat (10) @(posedge clk);
      #2;
      rst = 1'b0;
      check(rdy, 1'b1);
      check(auxo, `AUX_RESET);
      peek(`CONTROL_PORT, `CONTROL_RESET);
      peek(`AUX_PORT, {4'h9, `AUX_RESET});
      peek(`STATUS_PORT, 8'hD5);
      peek(8'hCF, 8'h00);
      io(1'b1, `CONTROL_PORT, 8'hF1);
      check(sctl, 8'hF1);
      io(1'b1, 8'hC0 + {4'h0, `IDX_BYTE_CLEAR}, 8'h00);
      prog(8'h0, 16'h0010, 16'h0003);
      prog(8'h2, 16'hE234, `RX_FRAME_COUNT);
      prog(8'h4, 16'h0500, `RX_FRAME_COUNT);
      prog(8'h6, 16'h0700, `RX_FRAME_COUNT);
      peek(8'hC2, 8'h34);
      peek(8'hC2, 8'hE2);
      io(1'b1, `SEQ_CLEAR_PORT, 8'h00);
      io(1'b1, `AVAIL1_PORT, 8'h00);
      check(avail_n, 1'b0);
      // first frame, slow far side, channel one
      frame(1'b0, 8'h02, 4'h3);
      wait_on(0, 1'b1);
      check(lock, 1'b0);
      @(posedge clk);
      #2;
      check({lock, grant}, 2'b10);
      @(posedge clk);
      #2;
      check({grant, rdy}, 2'b10);
      wait_on(1, 1'b1);
      check({address_enable, dhi}, 9'h1E2);
      wait_on(2, 1'b0);
      check(dma_memory_write_n_n, 1'b1);
      @(posedge clk);
      #2;
      check({dma_memory_write_n_n, maddr}, 14'h0234);
      finish_frame();
      check({seen, avail_n}, 4'h3);
      // second frame with a check error in normal mode: channel two reinitialised
      stat[5] = 1'b1;
      frame(1'b0, 8'h01, 4'h0);
      finish_frame();
      check({seen, waddr}, 16'h0500);
      peek(8'hC5, 8'hF1);
      peek(8'hC5, 8'h05);
      // third frame in diagnostic mode: completion on channel three
      io(1'b1, `CONTROL_PORT, 8'hEA);
      frame(1'b0, 8'h01, 4'h0);
      finish_frame();
      check({seen, waddr}, 16'h8700);
      stat[5] = 1'b0;
      // transmit block with the request dropped early; engine read refused meanwhile
      frame(1'b1, 8'hFF, 4'h2);
      wait_on(0, 1'b1);
      peek(8'hC1, 8'h00);
      finish_frame();
      check({nrd[3:0], niw[3:0], neop[7:0]}, 16'h3301);
      peek(8'hC1, 8'h03);
      peek(8'hC1, 8'h00);
      conclude();
   end
endmodule
`default_nettype wire
